// *** testbench/tcss_sva.sv ***
// port assertions for the timer block
`timescale 1ns/100ps
module tcss_sva
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  dtc_ack_a,
	input wire logic [1:0]  timer_out_pin,
	input wire logic [1:0]  timer_out_en,
	input wire logic [1:0]  compare_a_irq,
	input wire logic [1:0]  overflow_irq,
	input wire logic        adc_start_req
);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// access phase and write strobe
	wire acc = psel && penable;
	wire wr  = acc && pwrite;
	a_ready_high: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (acc && paddr == 8'hfc |-> pslverr)
		else $error("unmapped not refused");
	a_err_access: assert property (pslverr |-> acc)
		else $error("stray pslverr");
	a_adc_pulse: assert property (adc_start_req |=> !adc_start_req)
		else $error("adc request too long");
	a_en_holds: assert property (!wr |=> $stable(timer_out_en))
		else $error("enable moved");
	a_pin_gated: assert property ($changed(timer_out_pin[0])
		|-> $past(timer_out_en[0])) else $error("pin moved while off");
	a_flag_clear: assert property ($fell(compare_a_irq[0])
		|-> $past(wr) || $past(dtc_ack_a[0])) else $error("flag a lost");
	a_ovf_clear: assert property ($fell(overflow_irq[1])
		|-> $past(wr)) else $error("overflow flag lost");
endmodule
bind tcss_top tcss_sva u_sva (.*);

// *** testbench/timer_clock_select_and_status_bench.sv ***
// self-checking bench for the two-channel timer block
`timescale 1ns/100ps
module timer_clock_select_and_status_bench;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0;
	logic        penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0]  ext_clk_in = 2'h0, dtc_ack_a = 2'h0, dtc_ack_b = 2'h0;
	logic [1:0]  timer_out_pin, timer_out_en, compare_a_irq;
	logic [1:0]  compare_b_irq, overflow_irq;
	logic        pready, pslverr, adc_start_req, er;
	int          n_fail = 0, comparisons = 0, seed = 36077;
	int          n_adc = 0, tn, t0, tc, e, m;
	int          tbl[$] = '{516, 133, 518, 135, 4104, 2057, 4106, 2059,
		524300, 65549, 524302, 65551};
	tcss_top DUT (.*);
	always #25 pclk = ~pclk;
	// count adc start pulses mid-cycle
	always @(negedge pclk) if (adc_start_req === 1'h1) n_adc++;
	task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
		comparisons++;
		if (s !== x)
		begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one apb transfer, answer taken in the access phase
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		logic r;
		r = 1'h0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (int k = 0; k < 8 && r !== 1'h1; k++)
		begin
			@(posedge pclk);
			r = pready;
			rd = prdata;
			er = pslverr;
		end
		psel <= 1'h0;
		penable <= 1'h0;
		if (r !== 1'h1)
		begin
			chk("pready", r, 1);
			complete_run;
		end
		@(posedge pclk);
	endtask
	task automatic w(logic [7:0] a, logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rc(string nm, logic [7:0] a, logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(nm, rd, x);
	endtask
	// wait for a pin 0 change, time it in tn
	task automatic wpin;
		logic p;
		@(negedge pclk);
		p = timer_out_pin[0];
		for (int k = 0; k < 20000; k++)
		begin
			@(negedge pclk);
			if (timer_out_pin[0] !== p)
			begin
				tn = int'($time);
				@(posedge pclk);
				return;
			end
		end
		chk("pin wait", 0, 1);
		complete_run;
	endtask
	// pulses on the external clock pins
	task automatic pulse(logic [1:0] msk, int n);
		repeat (n)
		begin
			ext_clk_in <= msk;
			repeat (3) @(posedge pclk);
			ext_clk_in <= 2'h0;
			repeat (3) @(posedge pclk);
		end
	endtask
	task automatic ack(logic [1:0] msk);
		dtc_ack_a <= msk;
		dtc_ack_b <= msk;
		@(posedge pclk);
		dtc_ack_a <= 2'h0;
		dtc_ack_b <= 2'h0;
		@(posedge pclk);
	endtask
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		chk("pin", {timer_out_en, timer_out_pin}, 4'h0);
		rc("s0", tcss_pkg::OFS_STAT0, 8'h00);
		rc("s1", tcss_pkg::OFS_STAT1, 8'h10);
		w(tcss_pkg::OFS_STAT1, 32'hef);
		rc("s1", tcss_pkg::OFS_STAT1, 8'h1f);
		chk("en", timer_out_en, 2'h2);
		apb(1'h0, 8'hfc, 32'h0);
		chk("err", er, 1);
		chk("rd", rd, 0);
		$display("registers done");
		tc = 8 + ({$random(seed)} % 240); // clear of early counts
		w(tcss_pkg::OFS_TCA0, tc);
		w(tcss_pkg::OFS_STAT0, 32'h13);
		foreach (tbl[i])
		begin
			e = tbl[i];
			w(tcss_pkg::OFS_CCTL0, e & 3);
			w(tcss_pkg::OFS_CTL0, 32'h40 | ((e >> 2) & 7));
			w(tcss_pkg::OFS_CNT0, (tc - 1) & 255);
			wpin;
			t0 = tn;
			if (e >= 512)
				w(tcss_pkg::OFS_CNT0, (tc - 1) & 255);
			wpin;
			m = (e >= 512 ? 2 : 256) * (e >> 6) * 50;
			chk("period", tn - t0, m);
		end
		w(tcss_pkg::OFS_CTL0, 32'h40);
		chk("adc", n_adc, 24);
		chk("irq0", {overflow_irq[0], compare_b_irq[0], compare_a_irq[0]}, 1);
		rc("s0", tcss_pkg::OFS_STAT0, 8'hf3);
		w(tcss_pkg::OFS_STAT0, 32'hff);
		rc("s0", tcss_pkg::OFS_STAT0, 8'hff);
		w(tcss_pkg::OFS_STAT0, 32'h03);
		rc("s0", tcss_pkg::OFS_STAT0, 8'h03);
		w(tcss_pkg::OFS_CTL0, 32'h41);
		w(tcss_pkg::OFS_CNT0, (tc - 1) & 255);
		wpin;
		chk("adc", n_adc, 24);
		$display("prescaler done");
		for (int c = 5; c < 8; c++)
		begin
			m = 2 + ({$random(seed)} % 6);
			w(tcss_pkg::OFS_CNT1, 32'h0);
			w(tcss_pkg::OFS_CTL1, c);
			pulse(2'h2, m);
			rc("c1", tcss_pkg::OFS_CNT1, c == 7 ? 2 * m : m);
		end
		$display("external done");
		w(tcss_pkg::OFS_TCB1, 32'hfe);
		w(tcss_pkg::OFS_STAT1, 32'h09);
		w(tcss_pkg::OFS_CNT1, 32'hfd);
		w(tcss_pkg::OFS_CTL1, 32'ha5);
		pulse(2'h2, 2);
		chk("pin1", timer_out_pin[1], 1);
		chk("irqb1", compare_b_irq[1], 1);
		rc("s1", tcss_pkg::OFS_STAT1, 8'h99);
		pulse(2'h2, 1);
		chk("pin1", timer_out_pin[1], 0);
		chk("irq1", {overflow_irq[1], compare_a_irq[1]}, 2);
		w(tcss_pkg::OFS_STAT1, 32'h19);
		rc("s1", tcss_pkg::OFS_STAT1, 8'h79);
		w(tcss_pkg::OFS_DTC, 32'h2);
		ack(2'h2);
		rc("s1", tcss_pkg::OFS_STAT1, 8'h79);
		w(tcss_pkg::OFS_DTC, 32'h0);
		ack(2'h2);
		rc("s1", tcss_pkg::OFS_STAT1, 8'h39);
		w(tcss_pkg::OFS_STAT1, 32'h19);
		rc("s1", tcss_pkg::OFS_STAT1, 8'h19);
		$display("flags done");
		// one side at a time in cascade
		w(tcss_pkg::OFS_CTL1, 32'h05);
		w(tcss_pkg::OFS_CNT1, 32'hff);
		w(tcss_pkg::OFS_CTL0, 32'h04);
		w(tcss_pkg::OFS_CNT0, 32'h0);
		pulse(2'h2, 1);
		rc("c0", tcss_pkg::OFS_CNT0, 8'h01);
		w(tcss_pkg::OFS_CTL0, 32'h05);
		w(tcss_pkg::OFS_CNT0, tc);
		w(tcss_pkg::OFS_CTL1, 32'h04);
		w(tcss_pkg::OFS_CNT1, 32'h0);
		pulse(2'h1, 1);
		rc("c1", tcss_pkg::OFS_CNT1, 8'h01);
		$display("cascade done");
		complete_run;
	end
endmodule

// *** verilog/tcss_pkg.sv ***
// constants for the two-channel timer clock select and status block
package tcss_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_CNT0   = 8'h00;
	localparam logic [7:0] OFS_TCA0   = 8'h04;
	localparam logic [7:0] OFS_TCB0   = 8'h08;
	localparam logic [7:0] OFS_CTL0   = 8'h0c;
	localparam logic [7:0] OFS_CCTL0  = 8'h10;
	localparam logic [7:0] OFS_STAT0  = 8'h14;
	localparam logic [7:0] OFS_CNT1   = 8'h20;
	localparam logic [7:0] OFS_TCA1   = 8'h24;
	localparam logic [7:0] OFS_TCB1   = 8'h28;
	localparam logic [7:0] OFS_CTL1   = 8'h2c;
	localparam logic [7:0] OFS_CCTL1  = 8'h30;
	localparam logic [7:0] OFS_STAT1  = 8'h34;
	localparam logic [7:0] OFS_DTC    = 8'h40;
	localparam logic [7:0] CH_STRIDE  = 8'h20;
	// status register fields
	localparam int BIT_FLAG_B  = 7;
	localparam int BIT_FLAG_A  = 6;
	localparam int BIT_OVF     = 5;
	localparam int BIT_ADC_TRIGGER_ENABLE    = 4;
	// control register fields
	localparam int BIT_IE_B    = 7;
	localparam int BIT_IE_A    = 6;
	localparam int BIT_IE_OVF  = 5;
	// reset values
	localparam logic [7:0] RST_CNT   = 8'h00;
	localparam logic [7:0] RST_TC    = 8'hff;
	localparam logic [7:0] RST_STAT1 = 8'h10;
	localparam logic [7:0] CNT_MAX   = 8'hff;
	// clock select codes
	localparam logic [2:0] CKS_OFF     = 3'h0;
	localparam logic [2:0] CKS_DIV_LO  = 3'h1;
	localparam logic [2:0] CKS_DIV_MID = 3'h2;
	localparam logic [2:0] CKS_DIV_HI  = 3'h3;
	localparam logic [2:0] CKS_CASC    = 3'h4;
	localparam logic [2:0] CKS_EXT_R   = 3'h5;
	localparam logic [2:0] CKS_EXT_F   = 3'h6;
	localparam logic [2:0] CKS_EXT_B   = 3'h7;
	// prescaler tap positions: divide by 2^(n+1)
	localparam int TAP_D2    = 0;
	localparam int TAP_D8    = 2;
	localparam int TAP_D32   = 4;
	localparam int TAP_D64   = 5;
	localparam int TAP_D1024 = 9;
	localparam int TAP_D8192 = 12;
	localparam int PRE_W     = 13;
	// output select actions
	localparam logic [1:0] OS_KEEP = 2'h0;
	localparam logic [1:0] OS_LOW  = 2'h1;
	localparam logic [1:0] OS_HIGH = 2'h2;
	localparam logic [1:0] OS_TOG  = 2'h3;
endpackage

// *** verilog/tcss_top.sv ***
// two 8-bit timer channels: clock select, status flags, compare output
`timescale 1ns/100ps
module tcss_top
#(
	parameter int N_CH = 2
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  ext_clk_in,
	input  wire logic [1:0]  dtc_ack_a,
	input  wire logic [1:0]  dtc_ack_b,
	output logic      [1:0]  timer_out_pin,
	output logic      [1:0]  timer_out_en,
	output logic      [1:0]  compare_a_irq,
	output logic      [1:0]  compare_b_irq,
	output logic      [1:0]  overflow_irq,
	output logic             adc_start_req
);
	logic [tcss_pkg::PRE_W-1:0] pre_r;
	logic [tcss_pkg::PRE_W-1:0] pre_rise;
	logic [tcss_pkg::PRE_W-1:0] pre_fall;
	logic [1:0]  ext_d_r;
	logic [1:0]  count_tick;
	logic [1:0]  wrap_ev;
	logic [1:0]  match_a;
	logic [1:0]  match_b;
	logic [7:0]  cnt_r     [2];
	logic [7:0]  tca_r     [2];
	logic [7:0]  tcb_r     [2];
	logic [7:0]  ctl_r     [2];
	logic [1:0]  icks_r    [2];
	logic [2:0]  flag_r    [2];
	logic [2:0]  seen_r    [2];
	logic [3:0]  osel_r    [2];
	logic        adc_trigger_enable_r;
	logic [1:0]  dtc_irq_disable_select_r;
	logic        wr_en;
	logic        rd_en;
	logic        ch_idx;
	logic [7:0]  reg_ofs;
	logic        addr_ok;

	// apb access strobes and channel decode
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign ch_idx = (paddr >= tcss_pkg::CH_STRIDE) &&
		(paddr < tcss_pkg::OFS_DTC);
	assign reg_ofs = ch_idx ? paddr - tcss_pkg::CH_STRIDE : paddr;
	assign pready = 1'b1;

	// free-running prescaler of the peripheral clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre_r <= '0;
		else
			pre_r <= pre_r + 1'b1;
	end

	// prescaler edges and external pin history
	logic [tcss_pkg::PRE_W-1:0] pre_nxt;
	assign pre_nxt = pre_r + 1'b1;
	assign pre_rise = ~pre_r & pre_nxt;
	assign pre_fall = pre_r & ~pre_nxt;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ext_d_r <= 2'h0;
		else
			ext_d_r <= ext_clk_in;
	end

	// cascade wiring and channel decode serve exactly two channels
	generate
		if (N_CH != 2)
		begin : g_bad_cfg
			$error("tcss_top serves exactly two channels");
		end
	endgenerate

	// per-channel tick, match and wrap logic
	genvar g;
	generate
		for (g = 0; g < N_CH; g++)
		begin : g_ch
			logic [2:0] cks;
			logic       fall_sel;
			logic       lo_sel;
			logic [tcss_pkg::PRE_W-1:0] edges;
			logic       casc_src;
			logic       er;
			logic       ef;
			assign cks = ctl_r[g][2:0];
			assign fall_sel = icks_r[g][1];
			assign lo_sel = icks_r[g][0];
			assign edges = fall_sel ? pre_fall : pre_rise;
			assign er = ext_clk_in[g] & ~ext_d_r[g];
			assign ef = ~ext_clk_in[g] & ext_d_r[g];
			// channel 0 takes channel 1 wrap, channel 1 takes match a
			assign casc_src = (g == 0) ? wrap_ev[1] : match_a[0];
			always_comb
			begin
				case (cks)
					tcss_pkg::CKS_DIV_LO:
						count_tick[g] = lo_sel ?
							edges[tcss_pkg::TAP_D2] : edges[tcss_pkg::TAP_D8];
					tcss_pkg::CKS_DIV_MID:
						count_tick[g] = lo_sel ?
							edges[tcss_pkg::TAP_D32] : edges[tcss_pkg::TAP_D64];
					tcss_pkg::CKS_DIV_HI:
						count_tick[g] = lo_sel ? edges[tcss_pkg::TAP_D1024]
							: edges[tcss_pkg::TAP_D8192];
					tcss_pkg::CKS_CASC:
						count_tick[g] = casc_src;
					tcss_pkg::CKS_EXT_R:
						count_tick[g] = er;
					tcss_pkg::CKS_EXT_F:
						count_tick[g] = ef;
					tcss_pkg::CKS_EXT_B:
						count_tick[g] = er | ef;
					default:
						count_tick[g] = 1'b0;
				endcase
			end
			// match fires as the counter leaves the equal value
			assign match_a[g] = count_tick[g] && cnt_r[g] == tca_r[g];
			assign match_b[g] = count_tick[g] && cnt_r[g] == tcb_r[g];
			assign wrap_ev[g] = count_tick[g] &&
				cnt_r[g] == tcss_pkg::CNT_MAX;

			// counter, compare constants and controls
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cnt_r[g] <= tcss_pkg::RST_CNT;
					tca_r[g] <= tcss_pkg::RST_TC;
					tcb_r[g] <= tcss_pkg::RST_TC;
					ctl_r[g] <= 8'h00;
					icks_r[g] <= 2'h0;
					osel_r[g] <= 4'h0;
				end
				else
				begin
					if (wr_en && ch_idx == g)
					begin
						case (reg_ofs)
							tcss_pkg::OFS_TCA0:  tca_r[g] <= pwdata[7:0];
							tcss_pkg::OFS_TCB0:  tcb_r[g] <= pwdata[7:0];
							tcss_pkg::OFS_CTL0:  ctl_r[g] <= pwdata[7:0];
							tcss_pkg::OFS_CCTL0: icks_r[g] <= pwdata[1:0];
							tcss_pkg::OFS_STAT0: osel_r[g] <= pwdata[3:0];
							default:             ;
						endcase
					end
					// a counter write beats a tick; others keep counting
					if (wr_en && ch_idx == g &&
						reg_ofs == tcss_pkg::OFS_CNT0)
						cnt_r[g] <= pwdata[7:0];
					else if (count_tick[g])
						cnt_r[g] <= cnt_r[g] + 8'h01;
				end
			end

			// flags: {b, a, ovf}; set beats clear
			logic [2:0] set_ev;
			logic [2:0] sw_clr;
			logic [2:0] hw_clr;
			assign set_ev = {match_b[g], match_a[g], wrap_ev[g]};
			assign sw_clr = (wr_en && ch_idx == g &&
				reg_ofs == tcss_pkg::OFS_STAT0) ?
				(~pwdata[7:5] & seen_r[g]) : 3'h0;
			assign hw_clr = {dtc_ack_b[g] & ~dtc_irq_disable_select_r[g],
				dtc_ack_a[g] & ~dtc_irq_disable_select_r[g], 1'b0};
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					flag_r[g] <= 3'h0;
				else
					flag_r[g] <= set_ev | (flag_r[g] & ~(sw_clr | hw_clr));
			end

			// remember flags read as 1 to arm the software clear
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					seen_r[g] <= 3'h0;
				else if (rd_en && ch_idx == g &&
					reg_ofs == tcss_pkg::OFS_STAT0)
					seen_r[g] <= flag_r[g];
				else
					seen_r[g] <= seen_r[g] & flag_r[g];
			end

			// compare output pin
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					timer_out_pin[g] <= 1'b0;
				else if (match_b[g] && osel_r[g][3:2] != tcss_pkg::OS_KEEP)
					case (osel_r[g][3:2])
						tcss_pkg::OS_LOW:  timer_out_pin[g] <= 1'b0;
						tcss_pkg::OS_HIGH: timer_out_pin[g] <= 1'b1;
						default:           timer_out_pin[g] <= ~timer_out_pin[g];
					endcase
				else if (match_a[g] && osel_r[g][1:0] != tcss_pkg::OS_KEEP)
					case (osel_r[g][1:0])
						tcss_pkg::OS_LOW:  timer_out_pin[g] <= 1'b0;
						tcss_pkg::OS_HIGH: timer_out_pin[g] <= 1'b1;
						default:           timer_out_pin[g] <= ~timer_out_pin[g];
					endcase
			end
			// pin is driven only while some select bit is set
			assign timer_out_en[g] = |osel_r[g];

			// interrupt requests gated by enables
			assign compare_b_irq[g] = flag_r[g][2] &
				ctl_r[g][tcss_pkg::BIT_IE_B];
			assign compare_a_irq[g] = flag_r[g][1] &
				ctl_r[g][tcss_pkg::BIT_IE_A];
			assign overflow_irq[g] = flag_r[g][0] &
				ctl_r[g][tcss_pkg::BIT_IE_OVF];
		end
	endgenerate

	// adc trigger enable and transfer disable-select
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			adc_trigger_enable_r <= 1'b0;
			dtc_irq_disable_select_r <= 2'h0;
		end
		else if (wr_en && paddr == tcss_pkg::OFS_STAT0)
			adc_trigger_enable_r <= pwdata[tcss_pkg::BIT_ADC_TRIGGER_ENABLE];
		else if (wr_en && paddr == tcss_pkg::OFS_DTC)
			dtc_irq_disable_select_r <= pwdata[1:0];
	end

	// adc start pulse from channel 0 compare a
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			adc_start_req <= 1'b0;
		else
			adc_start_req <= match_a[0] & adc_trigger_enable_r;
	end

	// read data mux and unmapped decode
	always_comb
	begin
		addr_ok = 1'b1;
		prdata = 32'h0000_0000;
		case (reg_ofs)
			tcss_pkg::OFS_CNT0:  prdata[7:0] = cnt_r[ch_idx];
			tcss_pkg::OFS_TCA0:  prdata[7:0] = tca_r[ch_idx];
			tcss_pkg::OFS_TCB0:  prdata[7:0] = tcb_r[ch_idx];
			tcss_pkg::OFS_CTL0:  prdata[7:0] = ctl_r[ch_idx];
			tcss_pkg::OFS_CCTL0: prdata[1:0] = icks_r[ch_idx];
			tcss_pkg::OFS_STAT0:
				prdata[7:0] = {flag_r[ch_idx],
					ch_idx ? 1'b1 : adc_trigger_enable_r, osel_r[ch_idx]};
			default:
			begin
				if (paddr == tcss_pkg::OFS_DTC)
					prdata[1:0] = dtc_irq_disable_select_r;
				else
					addr_ok = 1'b0;
			end
		endcase
	end
	// error answer for unmapped addresses, zero wait states
	assign pslverr = psel && penable && !addr_ok;
endmodule
